// >>> verilog/fpd_pkg.sv
// Constants and types for the flash routine download sequencer
package fpd_pkg;
    localparam int          ADDR_W       = 24;
    localparam int          DL_BYTES     = 4096;
    localparam int          CNT_W        = 12;
    localparam logic [7:0]  KEY_OK       = 8'ha5;
    localparam logic [7:0]  TGT_MAX      = 8'h02;
    localparam logic [23:0] BASE_0       = 24'hff9000;
    localparam logic [23:0] BASE_1       = 24'hffa000;
    localparam logic [23:0] BASE_2       = 24'hffb000;
    localparam logic [7:0]  TGT_0        = 8'h00;
    localparam logic [7:0]  TGT_1        = 8'h01;
    localparam int          FAIL_BIT     = 0;
    localparam int          KEY_BIT      = 1;
    localparam int          SS_BIT       = 2;
    localparam int          RES_LO_BIT   = 3;
    localparam int          RES_HI_BIT   = 7;
    localparam logic [4:0]  RES_UNUSED   = 5'h00;
    localparam logic [11:0] CNT_LAST     = 12'hfff;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_COPY   = 5'h02,
        ST_VERIFY = 5'h04,
        ST_RESULT = 5'h08,
        ST_SPARE  = 5'h10
    } fpd_state_type;
endpackage

// >>> verilog/fpd_download.sv
// Download sequencer: copies a built-in routine to RAM, checks it, writes the result byte
`timescale 1ns/1ps
module fpd_download
    import fpd_pkg::*;
#(
    parameter int SEL_W = 3,
    parameter logic [SEL_W-1:0] SEL_MAPPED = 3'h7
)(
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic              download_start_bit,
    input  wire logic [7:0]        ram_target_select_register,
    input  wire logic              target_error_clear,
    input  wire logic [7:0]        flash_unlock_key_register,
    input  wire logic [SEL_W-1:0]  routine_select,
    output logic [CNT_W-1:0]       rom_addr,
    input  wire logic [7:0]        rom_rdata,
    output logic                   ram_we,
    output logic [ADDR_W-1:0]      ram_addr,
    output logic [7:0]             ram_wdata,
    input  wire logic [7:0]        ram_rdata,
    output logic                   busy,
    output logic                   download_done,
    output logic                   target_address_error,
    output logic [7:0]             download_result_byte,
    input  wire logic              routine_done,
    input  wire logic [15:0]       routine_result,
    output logic [15:0]            return_register
);
    fpd_state_type             state;
    logic                      phase;
    logic [CNT_W-1:0]          cnt;
    logic [ADDR_W-1:0]         base_q;
    logic                      sel_err_q;
    logic                      key_err_q;
    logic                      mismatch_q;

    wire                  start     = download_start_bit && (state == ST_IDLE);
    wire                  tgt_bad   = ram_target_select_register > TGT_MAX;
    wire                  start_ok  = start && !tgt_bad;
    wire                  sel_err   = !$onehot(routine_select)
                                      || ((routine_select & ~SEL_MAPPED) != '0);
    wire                  key_err   = flash_unlock_key_register != KEY_OK;
    wire [ADDR_W-1:0]     base_sel  = (ram_target_select_register == TGT_0) ? BASE_0 :
                                      (ram_target_select_register == TGT_1) ? BASE_1 : BASE_2;
    wire                  last      = phase && (cnt == CNT_LAST);
    wire                  fail      = sel_err_q || key_err_q;
    wire [ADDR_W-1:0]     cur_addr  = base_q + ADDR_W'(cnt);
    wire [7:0]            res_byte  = {RES_UNUSED, sel_err_q, key_err_q,
                                       fail || mismatch_q};
    wire                  mism_now  = (state == ST_VERIFY) && phase && (ram_rdata != rom_rdata);

    assign rom_addr = cnt;
    assign busy     = state != ST_IDLE;

    // Sequencer
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state         <= ST_IDLE;
            phase         <= 1'b0;
            cnt           <= '0;
            download_done <= 1'b0;
            ram_we        <= 1'b0;
        end else begin
            download_done <= 1'b0;
            ram_we        <= 1'b0;
            case (state)
                ST_IDLE: begin
                    phase <= 1'b0;
                    cnt   <= '0;
                    if (start_ok) begin
                        state <= (sel_err || key_err) ? ST_RESULT : ST_COPY;
                    end
                end
                ST_COPY: begin
                    phase <= !phase;
                    if (phase) begin
                        ram_we <= 1'b1;
                        cnt    <= cnt + 1'b1;
                        if (last) begin
                            state <= ST_VERIFY;
                        end
                    end
                end
                ST_VERIFY: begin
                    phase <= !phase;
                    if (phase) begin
                        cnt <= cnt + 1'b1;
                        if (last) begin
                            state <= ST_RESULT;
                        end
                    end
                end
                ST_RESULT: begin
                    ram_we        <= 1'b1;
                    download_done <= 1'b1;
                    state         <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Checks latched at launch; the readback mismatch is sticky through verify
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sel_err_q  <= 1'b0;
            key_err_q  <= 1'b0;
            mismatch_q <= 1'b0;
            base_q     <= BASE_0;
        end else if (start_ok) begin
            sel_err_q  <= sel_err;
            key_err_q  <= key_err;
            mismatch_q <= 1'b0;
            base_q     <= base_sel;
        end else if (mism_now) begin
            mismatch_q <= 1'b1;
        end
    end

    // Set wins over a simultaneous clear
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            target_address_error <= 1'b0;
        end else if (start && tgt_bad) begin
            target_address_error <= 1'b1;
        end else if (target_error_clear) begin
            target_address_error <= 1'b0;
        end
    end

    // RAM port data; no reset so contents stay undefined as the interface expects
    always_ff @(posedge ref_clk) begin
        if (state == ST_RESULT) begin
            ram_addr             <= base_q;
            ram_wdata            <= res_byte;
            download_result_byte <= res_byte;
        end else if (!phase) begin
            ram_addr <= cur_addr;
        end else if (state == ST_COPY) begin
            ram_wdata <= rom_rdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (routine_done) begin
            return_register <= routine_result;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    bad_target_a: assert property (start && tgt_bad |=> target_address_error
        && state == ST_IDLE) else $error("bad target code did not abort");
    base_map_a: assert property (start_ok |=> base_q == $past(base_sel))
        else $error("download base not taken from target code");
    launch_a: assert property (start_ok && !sel_err && !key_err |=> state == ST_COPY)
        else $error("start bit did not launch the copy");
    key_flag_a: assert property (start_ok |=> key_err_q ==
        ($past(flash_unlock_key_register) != KEY_OK)) else $error("key check wrong");
    sel_flag_a: assert property (start_ok |=> sel_err_q == $past(sel_err))
        else $error("selection check wrong");
    result_word_a: assert property (state == ST_RESULT |=> ram_we
        && ram_addr == base_q && ram_wdata[RES_HI_BIT:RES_LO_BIT] == RES_UNUSED)
        else $error("result byte not written at base");
    fail_bit_a: assert property (state == ST_RESULT |=> ram_wdata[FAIL_BIT] ==
        (mismatch_q || sel_err_q || key_err_q) && ram_wdata[KEY_BIT] == key_err_q)
        else $error("result pass fail bit wrong");
    copy_range_a: assert property (ram_we && $past(state) != ST_RESULT
        |-> (ram_addr - base_q) < ADDR_W'(DL_BYTES)) else $error("write outside area");
    result_order_a: assert property (state == ST_RESULT && !fail
        |-> $past(state) == ST_VERIFY) else $error("result before readback");
    return_reg_a: assert property (routine_done |=>
        return_register == $past(routine_result)) else $error("return code lost");

    // Launch, refusal and abort
    err_skip_a: assert property (start_ok && (sel_err || key_err)
        |=> state == ST_RESULT)
        else $error("failed check did not skip the copy");
    bad_quiet_a: assert property (start && tgt_bad
        |=> !ram_we && !download_done)
        else $error("aborted download touched the RAM");
    busy_start_a: assert property (download_start_bit && busy && tgt_bad
        |=> !$rose(target_address_error))
        else $error("start while busy raised the target error");
    flag_hold_a: assert property (target_address_error && !target_error_clear
        |=> target_address_error)
        else $error("target error dropped without a clear");
    flag_quiet_a: assert property (!target_address_error && !(start && tgt_bad)
        |=> !target_address_error)
        else $error("target error rose without a bad start");

    // Copy and read-back
    copy_write_a: assert property (state == ST_COPY && phase
        |=> ram_we && ram_wdata == $past(rom_rdata)
        && ram_addr == base_q + ADDR_W'($past(cnt)))
        else $error("copied byte not written to its slot");
    verify_quiet_a: assert property (state == ST_VERIFY && $past(state) == ST_VERIFY
        |-> !ram_we)
        else $error("write during read-back");
    verify_addr_a: assert property (state == ST_VERIFY && phase
        |-> ram_addr == cur_addr)
        else $error("read-back address off its byte");
    mism_set_a: assert property (mism_now |=> mismatch_q)
        else $error("read-back mismatch not held");
    mism_clear_a: assert property (start_ok |=> !mismatch_q)
        else $error("old mismatch carried into a new download");
    walk_end_a: assert property (state == ST_RESULT && !fail
        |-> $past(cnt) == CNT_LAST)
        else $error("result before the last byte was read back");

    // Result byte
    done_write_a: assert property (download_done
        |-> !busy && ram_we && ram_addr == base_q)
        else $error("done pulse without the result write");
    done_pulse_a: assert property (download_done |=> !download_done)
        else $error("done pulse longer than one cycle");
    sel_bit_a: assert property (state == ST_RESULT
        |=> ram_wdata[SS_BIT] == sel_err_q && download_result_byte == ram_wdata)
        else $error("selection bit of the result byte wrong");
    unused_zero_a: assert property (download_done
        |-> download_result_byte[RES_HI_BIT:RES_LO_BIT] == RES_UNUSED)
        else $error("unused result bits not zero");
endmodule

// >>> tb/fpd_mem_model.sv
// On-chip RAM and built-in routine ROM model on the far side of the sequencer
`timescale 1ns/1ps
module fpd_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        corrupt,
    input  wire logic [11:0] rom_addr,
    output logic [7:0]       rom_rdata,
    input  wire logic        ram_we,
    input  wire logic [23:0] ram_addr,
    input  wire logic [7:0]  ram_wdata,
    output logic [7:0]       ram_rdata
);
    logic [7:0] mem [0:16383];
    assign rom_rdata = rom_addr[7:0] ^ {rom_addr[11:8], rom_addr[11:8]};
    assign ram_rdata = mem[ram_addr[13:0]];
    always @(posedge ref_clk) begin
        if (ram_we) begin
            // Flips one copied byte on request so that the read-back must fail
            mem[ram_addr[13:0]] <= (corrupt && ram_addr[11:0] == 12'h005) ? ~ram_wdata
                                                                         : ram_wdata;
        end
    end
endmodule

// >>> tb/flash_program_download_interface_test.sv
// Self-checking bench for the download sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module flash_program_download_interface_test;
    import fpd_pkg::*;
    logic        ref_clk = 1'b0, rstn = 1'b0, start = 1'b0, clr = 1'b0, corrupt = 1'b0;
    logic        rdone = 1'b0, ram_we, busy, done, terr;
    logic [7:0]  tgt = 8'h00, key = 8'h00, rom_rdata, ram_wdata, ram_rdata, res;
    logic [2:0]  sel = 3'h0;
    logic [11:0] rom_addr;
    logic [23:0] ram_addr;
    logic [31:0] arg0 = 32'h0000_0000, arg1 = 32'h0000_0000;
    logic [15:0] rreg;
    logic [2:0]  bad_sel [4] = '{3'b000, 3'b011, 3'b111, 3'b100};
    // Stub routine: its result code is folded from the two argument registers
    wire  [15:0] rres = arg0[15:0] ^ arg1[15:0];
    int          errors = 0, num_checks = 0, cyc = 0, n;
    always #12.5 ref_clk = ~ref_clk;
    // Routine 3'b100 is left unmapped so the unmapped-selection error is reachable
    fpd_download #(.SEL_MAPPED(3'h3)) dut (.ref_clk(ref_clk), .rstn(rstn),
        .download_start_bit(start), .ram_target_select_register(tgt),
        .target_error_clear(clr),
        .flash_unlock_key_register(key), .routine_select(sel), .rom_addr(rom_addr),
        .rom_rdata(rom_rdata), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
        .ram_rdata(ram_rdata), .busy(busy), .download_done(done), .target_address_error(terr),
        .download_result_byte(res), .routine_done(rdone), .routine_result(rres),
        .return_register(rreg));
    fpd_mem_model u_mem (.ref_clk(ref_clk), .corrupt(corrupt), .rom_addr(rom_addr),
        .rom_rdata(rom_rdata), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
        .ram_rdata(ram_rdata));
    task automatic summarize();
        if (errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Pulses the start bit and waits, bounded, for the done pulse
    task automatic run(input logic [7:0] t, input logic [7:0] k, input logic [2:0] s,
                       input int lim);
        tgt = t;
        key = k;
        sel = s;
        start = 1'b1;
        @(negedge ref_clk) start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < lim) begin
            @(negedge ref_clk) n++;
        end
    endtask
    // Software side: loads the argument registers and lets the routine finish
    task automatic call_routine(input logic [31:0] a0, input logic [31:0] a1);
        arg0 = a0;
        arg1 = a1;
        rdone = 1'b1;
        @(negedge ref_clk) rdone = 1'b0;
        @(negedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        repeat (3) @(negedge ref_clk);
        rstn = 1'b1;
        `CHK(busy, 1'b0)
        run(TGT_0, KEY_OK, 3'b001, 17000);
        `CHK(done, 1'b1)
        `CHK(busy, 1'b0)
        @(negedge ref_clk);
        `CHK(res, 8'h00)
        `CHK(u_mem.mem[14'h1000], 8'h00)
        for (int i = 1; i < 4096; i++) begin
            `CHK(u_mem.mem[14'h1000 + i], 8'(i) ^ {2{4'(i >> 8)}})
        end
        corrupt = 1'b1;
        run(TGT_1, KEY_OK, 3'b010, 17000);
        @(negedge ref_clk);
        corrupt = 1'b0;
        `CHK(res, 8'h01)
        `CHK(u_mem.mem[14'h2000], 8'h01)
        run(8'h02, 8'h5a, 3'b001, 10);
        `CHK(done, 1'b1)
        @(negedge ref_clk);
        `CHK(u_mem.mem[14'h3000], 8'h03)
        for (int j = 0; j < 4; j++) begin
            run(8'h02, KEY_OK, bad_sel[j], 10);
            @(negedge ref_clk);
            `CHK(res, 8'h05)
        end
        for (int t = 3; t < 260; t += 252) begin
            run(8'(t), KEY_OK, 3'b001, 6);
            `CHK(done, 1'b0)
            `CHK(terr, 1'b1)
            `CHK(busy, 1'b0)
            clr = 1'b1;
            @(negedge ref_clk) clr = 1'b0;
            `CHK(terr, 1'b0)
        end
        @(negedge ref_clk);
        tgt = 8'h03;
        start = 1'b1;
        clr = 1'b1;
        @(negedge ref_clk) start = 1'b0;
        `CHK(terr, 1'b1)
        @(negedge ref_clk) clr = 1'b0;
        `CHK(terr, 1'b0)
        // A start while busy is ignored; a reset then cuts the copy short
        run(8'h00, KEY_OK, 3'b001, 20);
        run(8'h07, KEY_OK, 3'b001, 1);
        `CHK(terr, 1'b0)
        `CHK(busy, 1'b1)
        rstn = 1'b0;
        @(negedge ref_clk);
        `CHK(busy, 1'b0)
        `CHK(ram_we, 1'b0)
        `CHK(rom_addr, 12'h000)
        rstn = 1'b1;
        run(8'h00, 8'h00, 3'b001, 10);
        `CHK(done, 1'b1)
        @(negedge ref_clk);
        `CHK(res, 8'h03)
        call_routine(32'h0028_0400, 32'h0000_0000);
        `CHK(rreg, 16'h0400)
        call_routine(32'h00ff_8000, 32'h0000_1080);
        `CHK(rreg, 16'h9080)
        call_routine(32'h0000_000b, 32'h0000_0000);
        `CHK(rreg, 16'h000b)
        summarize();
    end
endmodule
